// File: shared/ccr_defines.svh
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// Register offsets on the serial register port.
`define CCR_OFF_ADC_OTG     8'h03
`define CCR_OFF_CHG_CTRL    8'h04
`define CCR_OFF_FAST_CURR   8'h05
`define CCR_OFF_PRE_TERM    8'h06

// Field positions.
`define CCR_ADC_GO_BIT      7
`define CCR_ADC_CONT_BIT    6

// Power-on values of the four registers.
`define CCR_RST_ADC_OTG     8'h10
`define CCR_RST_CHG_CTRL    8'h5B
`define CCR_RST_FAST_CURR   8'hA6
`define CCR_RST_PRE_TERM    8'h22

// Writable bit masks; reserved positions are zero.
`define CCR_MASK_ADC_OTG    8'hFB
`define CCR_MASK_CHG_CTRL   8'hFF
`define CCR_MASK_FAST_CURR  8'hBF
`define CCR_MASK_PRE_TERM   8'hFF

// Bits of the charge-control register kept across watchdog expiry.
`define CCR_KEEP_WDOG_CHG   8'h0F

`endif

// File: shared/ccr_pkg.sv
package ccr_pkg;
    typedef enum logic [2:0] {
        CCR_ADC_IDLE = 3'b001,
        CCR_ADC_BUSY = 3'b010,
        CCR_ADC_CONT = 3'b100
    } ccr_adc_state_t;
endpackage

// File: shared/ccr_reg_if.sv
`timescale 1ns/1ns
// Carries one register's update request and its current value.
interface ccr_reg_if;
    logic       load;
    logic [7:0] load_val;
    logic [7:0] q;
    modport ctl (output load, output load_val, input q);
    modport reg_side (input load, input load_val, output q);
endinterface

// File: hdl/ccr_reg8.sv
`timescale 1ns/1ns
`include "ccr_defines.svh"
// One 8-bit register with a reset value and a writable mask.
module ccr_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK    = 8'hFF
) (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    ccr_reg_if.reg_side rif
);
    logic [7:0] val_r;

    // Reserved bits never store anything.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            val_r <= RST_VAL;
        end else if (rif.load) begin
            val_r <= rif.load_val & MASK;
        end
    end

    assign rif.q = val_r;
endmodule

// File: hdl/ccr_config_regs.sv
`timescale 1ns/1ns
`include "ccr_defines.svh"
// How it works
// - Writing 1 to bit 7 starts conversion; it reads 1 while conversion runs.
// - In continuous mode host writes to the conversion go bit are ignored.
// - Bit 6 picks one-shot (0) or continuous (1) conversion; resets to 0.
// - Bits 5:3 set OTG voltage, 4.8 V base, 100 mV step, default 010.
// - Bits 1:0 set OTG current limit 0.5 to 1.5 A, default 00.
// - Charge-control bit 7 enables the battery load sink; resets to 0.
// - Charge-control bit 6 enables the status pin; resets to 1.
// - Bits 5:4 pick charge off, charge on, reserved or OTG; default 01.
// - Bits 3:1 set minimum system voltage 3 V to 3.75 V; default 101.
// - Bit 0 picks 100 mV or 150 mV track voltage; default 150 mV.
// - Charge-current bit 7 picks 2.8 V or 3.0 V pre-charge threshold; default 1.
// - Bits 5:0 set fast charge current, 320 mA base, 42 mA step, default 100110.
// - Bits 7:4 set pre-charge current, 150 mA base, 40 mA step, default 0010.
// - Bits 3:0 set termination current, 120 mA base, 40 mA step, default 0010.
// - A register reset request restores all four registers to power-on values.
module ccr_config_regs (
    input  wire logic       clk_sys_in,
    input  wire logic       srst_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] rd_addr_in,
    input  wire logic       reg_reset_in,
    input  wire logic       watchdog_expiry_in,
    input  wire logic       adc_done_in,
    output logic [7:0]      rd_data_out,
    output logic            adc_start_out,
    output logic            adc_cont_out,
    output logic [2:0]      otg_volt_code_out,
    output logic [1:0]      otg_curr_lim_code_out,
    output logic            batt_sink_on_out,
    output logic            stat_pin_en_out,
    output logic [1:0]      charge_op_sel_out,
    output logic [2:0]      sys_min_volt_code_out,
    output logic            batt_track_sel_out,
    output logic            precharge_thresh_sel_out,
    output logic [5:0]      fast_curr_code_out,
    output logic [3:0]      precharge_curr_code_out,
    output logic [3:0]      term_curr_code_out
);
    ccr_reg_if adc_if ();
    ccr_reg_if chg_if ();
    ccr_reg_if icc_if ();
    ccr_reg_if pre_if ();

    ccr_pkg::ccr_adc_state_t adc_st_r;
    ccr_pkg::ccr_adc_state_t adc_st_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic [7:0] adc_val;

    // Write strobes per register.
    wire logic wr_adc = wr_en_in && (wr_addr_in == `CCR_OFF_ADC_OTG);
    wire logic wr_chg = wr_en_in && (wr_addr_in == `CCR_OFF_CHG_CTRL);
    wire logic wr_icc = wr_en_in && (wr_addr_in == `CCR_OFF_FAST_CURR);
    wire logic wr_pre = wr_en_in && (wr_addr_in == `CCR_OFF_PRE_TERM);

    // Current mode and go bit, as stored.
    wire logic cont_now = adc_if.q[`CCR_ADC_CONT_BIT];
    wire logic go_now   = adc_if.q[`CCR_ADC_GO_BIT];

    // Go bit for a write: host value unless continuous mode locks it.
    wire logic go_wr = cont_now ? go_now : wr_data_in[`CCR_ADC_GO_BIT];

    // Go bit after the conversion engine acts: one-shot completion clears it.
    wire logic go_done = (adc_st_r == ccr_pkg::CCR_ADC_BUSY) && adc_done_in
                         && !cont_now;

    // Register-reset request restores everything to power-on values.
    wire logic restore_all = reg_reset_in;

    // Next value of the ADC/OTG register.
    always_comb begin
        adc_val = adc_if.q;
        if (wr_adc) begin
            adc_val = {go_wr, wr_data_in[6:0]};
        end
        if (go_done && !(wr_adc && go_wr)) begin
            adc_val[`CCR_ADC_GO_BIT] = 1'b0;
        end
    end

    // Register loads: a reset source wins over a host write.
    always_comb begin
        adc_if.load     = 1'b1;
        adc_if.load_val = adc_val;
        chg_if.load     = wr_chg;
        chg_if.load_val = wr_data_in;
        icc_if.load     = wr_icc;
        icc_if.load_val = wr_data_in;
        pre_if.load     = wr_pre;
        pre_if.load_val = wr_data_in;
        if (restore_all) begin
            adc_if.load_val = `CCR_RST_ADC_OTG;
            chg_if.load     = 1'b1;
            chg_if.load_val = `CCR_RST_CHG_CTRL;
            icc_if.load     = 1'b1;
            icc_if.load_val = `CCR_RST_FAST_CURR;
            pre_if.load     = 1'b1;
            pre_if.load_val = `CCR_RST_PRE_TERM;
        end else if (watchdog_expiry_in) begin
            adc_if.load_val = `CCR_RST_ADC_OTG;
            chg_if.load     = 1'b1;
            chg_if.load_val = (`CCR_RST_CHG_CTRL & ~`CCR_KEEP_WDOG_CHG)
                              | (chg_if.q & `CCR_KEEP_WDOG_CHG);
            icc_if.load     = 1'b1;
            icc_if.load_val = `CCR_RST_FAST_CURR;
            pre_if.load     = 1'b1;
            pre_if.load_val = `CCR_RST_PRE_TERM;
        end
    end

    // ADC/OTG register: go, mode, OTG voltage and current limit.
    ccr_reg8 #(
        .RST_VAL (`CCR_RST_ADC_OTG),
        .MASK    (`CCR_MASK_ADC_OTG)
    ) u_adc (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .rif        (adc_if.reg_side)
    );

    // Charge-control register: sink, status pin, operation, VSYS, track.
    ccr_reg8 #(
        .RST_VAL (`CCR_RST_CHG_CTRL),
        .MASK    (`CCR_MASK_CHG_CTRL)
    ) u_chg (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .rif        (chg_if.reg_side)
    );

    // Charge-current register: pre-charge threshold and fast current.
    ccr_reg8 #(
        .RST_VAL (`CCR_RST_FAST_CURR),
        .MASK    (`CCR_MASK_FAST_CURR)
    ) u_icc (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .rif        (icc_if.reg_side)
    );

    // Pre-charge and termination current register.
    ccr_reg8 #(
        .RST_VAL (`CCR_RST_PRE_TERM),
        .MASK    (`CCR_MASK_PRE_TERM)
    ) u_pre (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .rif        (pre_if.reg_side)
    );

    // Conversion tracker follows the go and mode bits being loaded this cycle.
    always_comb begin
        adc_st_nxt = adc_st_r;
        case (adc_st_r)
            ccr_pkg::CCR_ADC_IDLE: begin
                if (adc_val[`CCR_ADC_GO_BIT]) begin
                    adc_st_nxt = adc_val[`CCR_ADC_CONT_BIT] ? ccr_pkg::CCR_ADC_CONT
                                                            : ccr_pkg::CCR_ADC_BUSY;
                end
            end
            ccr_pkg::CCR_ADC_BUSY: begin
                if (!adc_val[`CCR_ADC_GO_BIT]) begin
                    adc_st_nxt = ccr_pkg::CCR_ADC_IDLE;
                end else if (adc_val[`CCR_ADC_CONT_BIT]) begin
                    adc_st_nxt = ccr_pkg::CCR_ADC_CONT;
                end
            end
            ccr_pkg::CCR_ADC_CONT: begin
                if (!adc_val[`CCR_ADC_GO_BIT]) begin
                    adc_st_nxt = ccr_pkg::CCR_ADC_IDLE;
                end else if (!adc_val[`CCR_ADC_CONT_BIT]) begin
                    adc_st_nxt = ccr_pkg::CCR_ADC_BUSY;
                end
            end
            default: begin
                adc_st_nxt = ccr_pkg::CCR_ADC_IDLE;
            end
        endcase
        if (restore_all || watchdog_expiry_in) begin
            adc_st_nxt = ccr_pkg::CCR_ADC_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            adc_st_r <= ccr_pkg::CCR_ADC_IDLE;
        end else begin
            adc_st_r <= adc_st_nxt;
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        if (rd_addr_in == `CCR_OFF_ADC_OTG) begin
            rd_data_nxt = adc_if.q & `CCR_MASK_ADC_OTG;
        end else if (rd_addr_in == `CCR_OFF_CHG_CTRL) begin
            rd_data_nxt = chg_if.q;
        end else if (rd_addr_in == `CCR_OFF_FAST_CURR) begin
            rd_data_nxt = icc_if.q & `CCR_MASK_FAST_CURR;
        end else if (rd_addr_in == `CCR_OFF_PRE_TERM) begin
            rd_data_nxt = pre_if.q;
        end else begin
            rd_data_nxt = 8'h00;
        end
    end

    // Registered read data and field outputs.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_out              = rd_data_r;
    assign adc_start_out            = adc_if.q[7];
    assign adc_cont_out             = adc_if.q[6];
    assign otg_volt_code_out        = adc_if.q[5:3];
    assign otg_curr_lim_code_out    = adc_if.q[1:0];
    assign batt_sink_on_out         = chg_if.q[7];
    assign stat_pin_en_out          = chg_if.q[6];
    assign charge_op_sel_out        = chg_if.q[5:4];
    assign sys_min_volt_code_out    = chg_if.q[3:1];
    assign batt_track_sel_out       = chg_if.q[0];
    assign precharge_thresh_sel_out = icc_if.q[7];
    assign fast_curr_code_out       = icc_if.q[5:0];
    assign precharge_curr_code_out  = pre_if.q[7:4];
    assign term_curr_code_out       = pre_if.q[3:0];
endmodule

// File: verification/ccr_config_regs_chk.sv
`timescale 1ns/1ns
// Ties register fields and read data to the requests that caused them.
module ccr_config_regs_chk (
    input wire logic       clk_sys_in,
    input wire logic       srst_in,
    input wire logic       wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic       reg_reset_in,
    input wire logic       watchdog_expiry_in,
    input wire logic       adc_done_in,
    input wire logic [7:0] rd_data_out,
    input wire logic       adc_start_out,
    input wire logic       adc_cont_out,
    input wire logic [1:0] charge_op_sel_out,
    input wire logic [2:0] sys_min_volt_code_out,
    input wire logic       batt_track_sel_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // A restore beats a host write, so writes are only counted without one.
    wire rs = reg_reset_in | watchdog_expiry_in;
    wire w3 = wr_en_in && (wr_addr_in == 8'h03) && !rs;
    // Go bit, mode bit, restores and read port.
    property p_go_set; w3 && wr_data_in[7] && !adc_cont_out |=> adc_start_out; endproperty
    a_go_set : assert property (p_go_set) else $error("go bit not set");
    property p_go_hold; adc_start_out && !adc_done_in && !rs && !w3 |=> adc_start_out; endproperty
    a_go_hold : assert property (p_go_hold) else $error("go bit dropped early");
    property p_go_ro; adc_cont_out && !rs |=> $stable(adc_start_out); endproperty
    a_go_ro : assert property (p_go_ro) else $error("go bit moved in continuous mode");
    property p_go_clr;
        adc_start_out && $past(adc_start_out) && adc_done_in && !adc_cont_out && !rs && !w3
        |=> !adc_start_out;
    endproperty
    a_go_clr : assert property (p_go_clr) else $error("go bit not cleared");
    property p_mode; w3 |=> adc_cont_out == $past(wr_data_in[6]); endproperty
    a_mode : assert property (p_mode) else $error("mode bit not written");
    property p_rrst;
        reg_reset_in |=> charge_op_sel_out == 2'b01 && sys_min_volt_code_out == 3'b101;
    endproperty
    a_rrst : assert property (p_rrst) else $error("register reset missed");
    property p_wdog;
        watchdog_expiry_in && !reg_reset_in |=> $stable(sys_min_volt_code_out)
            && $stable(batt_track_sel_out) && !adc_cont_out;
    endproperty
    a_wdog : assert property (p_wdog) else $error("watchdog restore wrong");
    property p_resv; rd_addr_in == 8'h03 |=> !rd_data_out[2]; endproperty
    a_resv : assert property (p_resv) else $error("reserved bit reads one");
    property p_unmap; !(rd_addr_in inside {[8'h03:8'h06]}) |=> rd_data_out == 8'h00; endproperty
    a_unmap : assert property (p_unmap) else $error("unmapped read not zero");
    c_rrst : cover property (reg_reset_in);
    c_wdog : cover property (watchdog_expiry_in);
    c_done : cover property (adc_done_in && adc_start_out && !adc_cont_out);
endmodule

// File: verification/ccr_adc_model.sv
`timescale 1ns/1ns
// Converter stand-in: answers a raised go bit with a done pulse after DLY+1 cycles.
module ccr_adc_model #(
    parameter int DLY = 4
) (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    input  wire logic go_in,
    output logic      done_out
);
    int cnt = 0;
    // Counts while go is high and repeats, as a continuous converter would.
    always @(posedge clk_sys_in) begin
        done_out <= 1'b0;
        if (srst_in || !go_in) begin
            cnt <= 0;
        end else if (cnt == DLY) begin
            done_out <= 1'b1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic       clk_sys_in = 0;
    logic       srst_in    = 1;
    logic       we         = 0;
    logic [7:0] wa         = 8'h00;
    logic [7:0] wdat       = 8'h00;
    logic [7:0] ra         = 8'h00;
    logic [1:0] pl         = 2'b00;
    logic       done;
    logic [7:0] rdat;
    wire  [7:0] f3, f4, f5, f6;
    logic [7:0] por [5] = '{8'h10, 8'h5B, 8'hA6, 8'h22, 8'h00};
    int         num_errors = 0;
    int         checked    = 0;
    int         cyc        = 0;
    // Free-running clock and a cycle ceiling against hangs.
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    ccr_config_regs i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wr_en_in(we),
        .wr_addr_in(wa), .wr_data_in(wdat), .rd_addr_in(ra), .reg_reset_in(pl[0]),
        .watchdog_expiry_in(pl[1]), .adc_done_in(done), .rd_data_out(rdat),
        .adc_start_out(f3[7]), .adc_cont_out(f3[6]), .otg_volt_code_out(f3[5:3]),
        .otg_curr_lim_code_out(f3[1:0]), .batt_sink_on_out(f4[7]), .stat_pin_en_out(f4[6]),
        .charge_op_sel_out(f4[5:4]), .sys_min_volt_code_out(f4[3:1]),
        .batt_track_sel_out(f4[0]), .precharge_thresh_sel_out(f5[7]),
        .fast_curr_code_out(f5[5:0]), .precharge_curr_code_out(f6[7:4]),
        .term_curr_code_out(f6[3:0]));
    ccr_adc_model i_adc (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .go_in(f3[7]),
        .done_out(done));
    task chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in) {we, wa, wdat} <= {1'b1, a, d};
        @(posedge clk_sys_in) we <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys_in) ra <= a;
        @(posedge clk_sys_in) #1 v = rdat;
    endtask
    task pulse(input logic [1:0] k);
        @(posedge clk_sys_in) pl <= k;
        @(posedge clk_sys_in) pl <= 2'b00;
        #1;
    endtask
    // Power-on values of the four registers and an unmapped offset.
    task t_por;
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            rd(8'(3 + i), v);
            chk(v, por[i]);
        end
    endtask
    // Every field but the ADC go and mode bits written away from its default; reserved bits stay zero.
    task t_fields;
        logic [7:0] v;
        wr(8'h03, 8'h3F);
        wr(8'h04, 8'hB4);
        wr(8'h05, 8'h7F);
        wr(8'h06, 8'h9C);
        wr(8'h07, 8'hFF);
        chk(f3 & 8'hFB, 8'h3B);
        chk(f4, 8'hB4);
        chk(f5 & 8'hBF, 8'h3F);
        chk(f6, 8'h9C);
        rd(8'h03, v);
        chk(v, 8'h3B);
        rd(8'h05, v);
        chk(v, 8'h3F);
        rd(8'h07, v);
        chk(v, 8'h00);
    endtask
    // Watchdog keeps the low nibble of charge control; register reset restores charge control.
    task t_restore;
        pulse(2'b10);
        chk(f3 & 8'hFB, 8'h10);
        chk(f4, 8'h54);
        chk(f5 & 8'hBF, 8'hA6);
        chk(f6, 8'h22);
        pulse(2'b01);
        chk(f4, 8'h5B);
    endtask
    // One-shot conversion clears itself; continuous mode freezes the go bit.
    task t_adc;
        int n;
        wr(8'h03, 8'h90);
        chk(f3[7], 1'b1);
        n = 0;
        while (f3[7] === 1'b1 && n < 20) begin
            @(posedge clk_sys_in) #1 n++;
        end
        chk(f3[7], 1'b0);
        wr(8'h03, 8'hC0);
        repeat (12) @(posedge clk_sys_in);
        #1 chk(f3[7:6], 2'b11);
        wr(8'h03, 8'h40);
        chk(f3[7], 1'b1);
        wr(8'h03, 8'h00);
        chk(f3[7:6], 2'b10);
        pulse(2'b01);
        chk(f3[7], 1'b0);
    endtask
    task tally_and_finish;
        $display("Errors: %0d, checks: %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        t_por();
        t_fields();
        t_restore();
        t_adc();
        tally_and_finish();
    end
endmodule
bind ccr_config_regs ccr_config_regs_chk i_chk (.*);
